// file: src/vpic_pkg.sv
// Shared constants for the vectored priority interrupt controller and its bench
package vpic_pkg;
	// ************************************************************
	// Source numbering, in fixed table order (0 ranks first)
	// ************************************************************
	localparam int NSRC      = 20;  // Total source positions
	localparam int SRC_RESET = 0;   // Reset vector position
	localparam int SRC_WDT   = 1;   // Watchdog timer interrupt
	localparam int SRC_POSC  = 2;   // Primary oscillator fail trap
	localparam int SRC_WOSC  = 3;   // Watchdog oscillator fail trap
	localparam int SRC_ILL   = 4;   // Illegal instruction trap
	localparam int NFIX      = 5;   // Positions that are always top level
	localparam int SRC_T1    = 5;   // Timer 1
	localparam int SRC_T0    = 6;   // Timer 0
	localparam int SRC_ADC   = 7;   // Converter
	localparam int SRC_PA7   = 8;   // Port A pin 7, pins follow downward
	localparam int SRC_PC3   = 16;  // Port C pin 3, pins follow downward
	localparam int NPA       = 8;   // Port A pins
	localparam int NPC       = 4;   // Port C pins
	localparam int PA_CMP    = 6;   // Port A pin sharing its slot with the comparator

	// ************************************************************
	// Vector locations in program memory
	// ************************************************************
	localparam logic [15:0] VEC_RESET = 16'h0002;
	localparam logic [15:0] VEC_WDT   = 16'h0004;
	localparam logic [15:0] VEC_POSC  = 16'h003A;
	localparam logic [15:0] VEC_WOSC  = 16'h003C;
	localparam logic [15:0] VEC_ILL   = 16'h0006;
	localparam logic [15:0] VEC_T1    = 16'h000A;
	localparam logic [15:0] VEC_T0    = 16'h000C;
	localparam logic [15:0] VEC_ADC   = 16'h0016;
	localparam logic [15:0] VEC_PA7   = 16'h0018;
	localparam logic [15:0] VEC_PC3   = 16'h0030;
	localparam logic [15:0] VEC_STEP  = 16'h0002;  // Spacing of consecutive pin vectors
	localparam logic [15:0] VEC_ODD   = 16'h0001;  // Low byte sits one above the even high byte

	// ************************************************************
	// Priority level encoding {enable high, enable low}
	// ************************************************************
	localparam logic [1:0] LVL_OFF = 2'h0;
	localparam logic [1:0] LVL_1   = 2'h1;
	localparam logic [1:0] LVL_2   = 2'h2;
	localparam logic [1:0] LVL_3   = 2'h3;

	// ************************************************************
	// Register map, byte wide, index on the plain port
	// ************************************************************
	localparam logic [3:0] REG_REQ0   = 4'h0;  // Timer and converter requests
	localparam logic [3:0] REG_EN0H   = 4'h1;
	localparam logic [3:0] REG_EN0L   = 4'h2;
	localparam logic [3:0] REG_REQ1   = 4'h3;  // Port A requests
	localparam logic [3:0] REG_EN1H   = 4'h4;
	localparam logic [3:0] REG_EN1L   = 4'h5;
	localparam logic [3:0] REG_REQ2   = 4'h6;  // Port C requests
	localparam logic [3:0] REG_EN2H   = 4'h7;
	localparam logic [3:0] REG_EN2L   = 4'h8;
	localparam logic [3:0] REG_EDGE   = 4'h9;  // Port A edge select, 1 = rising
	localparam logic [3:0] REG_CTRL   = 4'hA;  // Master enable
	localparam int         CTRL_EN_BIT = 7;
	localparam int         T1_BIT      = 6;
	localparam int         T0_BIT      = 5;
	localparam int         ADC_BIT     = 0;

	// Vector location of a source position
	function automatic logic [15:0] vec_of(input int idx);
		logic [15:0] v;
		v = VEC_RESET;
		case (idx)
			SRC_RESET: v = VEC_RESET;
			SRC_WDT:   v = VEC_WDT;
			SRC_POSC:  v = VEC_POSC;
			SRC_WOSC:  v = VEC_WOSC;
			SRC_ILL:   v = VEC_ILL;
			SRC_T1:    v = VEC_T1;
			SRC_T0:    v = VEC_T0;
			SRC_ADC:   v = VEC_ADC;
			default:
			begin
				if (idx >= SRC_PC3)
					v = VEC_PC3 + 16'((idx - SRC_PC3)) * VEC_STEP;
				else
					v = VEC_PA7 + 16'((idx - SRC_PA7)) * VEC_STEP;
			end
		endcase
		return v;
	endfunction : vec_of

	// Source position held by bit b of request group g, NSRC when reserved
	function automatic int src_of(input int g, input int b);
		int s;
		s = NSRC;
		case (g)
			0:
			begin
				if (b == T1_BIT)
					s = SRC_T1;
				else if (b == T0_BIT)
					s = SRC_T0;
				else if (b == ADC_BIT)
					s = SRC_ADC;
			end
			1: s = SRC_PA7 + (NPA - 1 - b);
			2: s = (b < NPC) ? SRC_PC3 + (NPC - 1 - b) : NSRC;
			default: s = NSRC;
		endcase
		return s;
	endfunction : src_of
endpackage : vpic_pkg

// file: src/vpic_if.sv
// Link between the interrupt controller and the processor core
`timescale 1ns/100ps
interface vpic_if;
	logic        irq_req;     // Controller offers a vector, level
	logic [15:0] vector;      // Fetched vector, valid with irq_req
	logic        ack;         // Core takes the offered vector, pulse
	logic        ei;          // Enable-interrupts executed, pulse
	logic        di;          // Disable-interrupts executed, pulse
	logic        return_from_handler_instruction;        // Return-from-handler executed, pulse
	logic        trap_instr;  // Trap instruction executed, pulse
	logic        ill_trap;    // Illegal instruction detected, pulse

	// Controller end
	modport dev (output irq_req, output vector,
		input ack, input ei, input di, input return_from_handler_instruction, input trap_instr, input ill_trap);
	// Core end
	modport core (input irq_req, input vector,
		output ack, output ei, output di, output return_from_handler_instruction, output trap_instr, output ill_trap);
endinterface : vpic_if

// file: src/vpic_core_end.sv
// Core-side end: issues instruction events and acknowledges offered vectors
`timescale 1ns/100ps
module vpic_core_end
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	vpic_if.core             link,
	input  wire logic        accept_in,      // Core may take an interrupt now
	input  wire logic        ei_in,          // Pipeline events, one-cycle pulses
	input  wire logic        di_in,
	input  wire logic        return_from_handler_instruction_in,
	input  wire logic        trap_in,
	input  wire logic        illegal_in,
	output logic      [15:0] vector_out,     // Taken vector
	output logic             vector_vld_out  // One cycle with a new vector
);
	// ************************************************************
	// Acknowledge sequencer
	// ************************************************************
	typedef enum logic [2:0]
	{
		VPC_IDLE = 3'h1,
		VPC_ACK  = 3'h2,
		VPC_GAP  = 3'h4
	} vpc_state_e;

	vpc_state_e  state;        // Sequencer state
	vpc_state_e  next_state;
	logic        ack;          // Registered acknowledge
	logic        next_ack;
	logic [15:0] next_vector;
	logic        next_vld;
	logic [4:0]  evt;          // Registered ei, di, return_from_handler_instruction, trap, illegal
	logic [4:0]  next_evt;

	// Next values: one acknowledge per offer, then a gap while the offer drops
	always_comb
	begin
		next_state  = state;
		next_ack    = 1'b0;
		next_vector = vector_out;
		next_vld    = 1'b0;
		next_evt    = {ei_in, di_in, return_from_handler_instruction_in, trap_in, illegal_in};
		case (state)
			VPC_IDLE:
			begin
				// Take the vector in the cycle the acknowledge goes out
				if (link.irq_req && accept_in)
				begin
					next_state  = VPC_ACK;
					next_ack    = 1'b1;
					next_vector = link.vector;
					next_vld    = 1'b1;
				end
			end
			VPC_ACK:  next_state = VPC_GAP;   // Offer is withdrawn after this edge
			VPC_GAP:  next_state = VPC_IDLE;  // Guards against a second acknowledge
			default:  next_state = VPC_IDLE;
		endcase
	end

	// Registers only
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state          <= VPC_IDLE;
			ack            <= 1'b0;
			vector_out     <= 16'h0000;
			vector_vld_out <= 1'b0;
			evt            <= 5'h00;
		end
		else
		begin
			state          <= next_state;
			ack            <= next_ack;
			vector_out     <= next_vector;
			vector_vld_out <= next_vld;
			evt            <= next_evt;
		end
	end

	// Link drive straight from flip-flops
	assign link.ack        = ack;
	assign link.ei         = evt[4];
	assign link.di         = evt[3];
	assign link.return_from_handler_instruction       = evt[2];
	assign link.trap_instr = evt[1];
	assign link.ill_trap   = evt[0];
endmodule : vpic_core_end

// file: src/vpic_ctrl.sv
// Interrupt controller end: request latching, ranking, vector fetch and master enable
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
// What this block does
// - Fetch vector high byte even, low odd
// - Reset 0002H, watchdog 0004H, top ranked
// - Oscillator fails 003AH, 003CH after watchdog
// - Illegal instruction 0006H after oscillator traps
// - Timer1, timer0, converter, port A, C
// - Port A pins selectable edge, 0018H-0026H
// - Port A6 and comparator share 001AH
// - Port C pins both edges, 0030H-0036H
// - Level 3 beats 2 beats 1
// - Same level resolved by table order
// - Fixed sources always ranked at level three
// - Enable set by ei, return_from_handler_instruction, write 1
// - Enable cleared by di, ack, traps, write 0
// - Sources pulse exactly one clock cycle
// - Acknowledge clears the matching pending bit
// - Writing 0 clears a pending request
// - Writing 1 raises an enabled request
// - Software uses atomic read-modify-write
// - Pending peripherals forwarded only while master enable set
// - Enable bits 00 off, else level 1-3
module vpic_ctrl
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	vpic_if.dev              link,
	input  wire logic        timer1_pulse_in,       // Same-clock request pulses
	input  wire logic        timer0_pulse_in,
	input  wire logic        adc_pulse_in,
	input  wire logic        cmp_pulse_in,
	input  wire logic        wdt_pulse_in,
	input  wire logic        wdt_irq_en_in,         // Watchdog runs in interrupt mode
	input  wire logic        posc_fail_in,
	input  wire logic        wosc_fail_in,
	input  wire logic [7:0]  pa_pin_in,             // Asynchronous pins
	input  wire logic [3:0]  pc_pin_in,
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	output logic      [15:0] mem_addr_out,          // Program memory, data one cycle later
	output logic             mem_rd_out,
	input  wire logic [7:0]  mem_data_in,
	output logic             master_irq_enable_out
);
	localparam int NS = vpic_pkg::NSRC;

	// ************************************************************
	// Pin synchronisers and edge detection
	// ************************************************************
	logic [11:0] pin_s1;       // First stage, read only by the second
	logic [11:0] pin_s2;
	logic [11:0] pin_s3;       // Previous synchronised level
	logic [11:0] next_s1;
	logic [11:0] next_s2;
	logic [11:0] next_s3;
	logic [7:0]  pa_edge;      // Port A edge event
	logic [3:0]  pc_edge;      // Port C edge event
	logic [7:0]  edge_sel;     // Port A edge select register

	always_comb
	begin
		next_s1 = {pa_pin_in, pc_pin_in};
		next_s2 = pin_s1;
		next_s3 = pin_s2;
		for (int i = 0; i < vpic_pkg::NPA; i++)
			pa_edge[i] = edge_sel[i] ? (pin_s2[i + 4] & ~pin_s3[i + 4])
			                         : (~pin_s2[i + 4] & pin_s3[i + 4]);
		pc_edge = pin_s2[3:0] ^ pin_s3[3:0];
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pin_s1 <= 12'h000;
			pin_s2 <= 12'h000;
			pin_s3 <= 12'h000;
		end
		else
		begin
			pin_s1 <= next_s1;
			pin_s2 <= next_s2;
			pin_s3 <= next_s3;
		end
	end

	// ************************************************************
	// Pending bits, enables and register port
	// ************************************************************
	logic [NS-1:0] pend;       // One pending bit per source position
	logic [NS-1:0] en_hi;      // Level bit high per position
	logic [NS-1:0] en_lo;      // Level bit low per position
	logic          irq_en;     // Master enable
	logic [NS-1:0] next_pend;
	logic [NS-1:0] next_en_hi;
	logic [NS-1:0] next_en_lo;
	logic [7:0]    next_edge;
	logic          next_irq_en;
	logic [7:0]    next_rdata;
	logic [NS-1:0] hw_set;     // Hardware events this cycle
	logic [NS-1:0] ack_clr;    // Position taken by the core
	logic          ack_take;   // Acknowledge lands on a live offer
	int            cur_idx;    // Offered position
	int            s;

	always_comb
	begin
		s          = 0;
		hw_set     = '0;
		ack_clr    = '0;
		next_pend  = pend;
		next_en_hi = en_hi;
		next_en_lo = en_lo;
		next_edge  = edge_sel;
		next_irq_en = irq_en;
		next_rdata = 8'h00;
		// Incoming pulses are taken one per cycle, never as levels
		hw_set[vpic_pkg::SRC_WDT]  = wdt_pulse_in & wdt_irq_en_in;
		hw_set[vpic_pkg::SRC_POSC] = posc_fail_in;
		hw_set[vpic_pkg::SRC_WOSC] = wosc_fail_in;
		hw_set[vpic_pkg::SRC_ILL]  = link.ill_trap;
		hw_set[vpic_pkg::SRC_T1]   = timer1_pulse_in;
		hw_set[vpic_pkg::SRC_T0]   = timer0_pulse_in;
		hw_set[vpic_pkg::SRC_ADC]  = adc_pulse_in;
		for (int i = 0; i < vpic_pkg::NPA; i++)
			hw_set[vpic_pkg::SRC_PA7 + vpic_pkg::NPA - 1 - i] = pa_edge[i];
		hw_set[vpic_pkg::SRC_PA7 + vpic_pkg::NPA - 1 - vpic_pkg::PA_CMP] =
			pa_edge[vpic_pkg::PA_CMP] | cmp_pulse_in;
		for (int i = 0; i < vpic_pkg::NPC; i++)
			hw_set[vpic_pkg::SRC_PC3 + vpic_pkg::NPC - 1 - i] = pc_edge[i];
		if (ack_take)
			ack_clr[cur_idx] = 1'b1;
		next_pend = pend & ~ack_clr;
		// Register writes: reserved bits map to no position and are dropped
		for (int g = 0; g < 3; g++)
			for (int b = 0; b < 8; b++)
			begin
				s = vpic_pkg::src_of(g, b);
				if (s < NS)
				begin
					if (reg_wr_in && reg_addr_in == vpic_pkg::REG_REQ0 + 4'(3 * g))
						next_pend[s] = reg_wdata_in[b];
					if (reg_wr_in && reg_addr_in == vpic_pkg::REG_EN0H + 4'(3 * g))
						next_en_hi[s] = reg_wdata_in[b];
					if (reg_wr_in && reg_addr_in == vpic_pkg::REG_EN0L + 4'(3 * g))
						next_en_lo[s] = reg_wdata_in[b];
					if (reg_rd_in && reg_addr_in == vpic_pkg::REG_REQ0 + 4'(3 * g))
						next_rdata[b] = pend[s];
					if (reg_rd_in && reg_addr_in == vpic_pkg::REG_EN0H + 4'(3 * g))
						next_rdata[b] = en_hi[s];
					if (reg_rd_in && reg_addr_in == vpic_pkg::REG_EN0L + 4'(3 * g))
						next_rdata[b] = en_lo[s];
				end
			end
		// Hardware set wins over a clearing write or an acknowledge
		next_pend = next_pend | hw_set;
		if (reg_wr_in && reg_addr_in == vpic_pkg::REG_EDGE)
			next_edge = reg_wdata_in;
		if (reg_rd_in && reg_addr_in == vpic_pkg::REG_EDGE)
			next_rdata = edge_sel;
		if (reg_rd_in && reg_addr_in == vpic_pkg::REG_CTRL)
			next_rdata[vpic_pkg::CTRL_EN_BIT] = irq_en;
		// Master enable: clearing events first, setting events override them
		if (link.di || ack_take || link.trap_instr || link.ill_trap || posc_fail_in || wosc_fail_in
			|| (reg_wr_in && reg_addr_in == vpic_pkg::REG_CTRL && !reg_wdata_in[vpic_pkg::CTRL_EN_BIT]))
			next_irq_en = 1'b0;
		if (link.ei || link.return_from_handler_instruction
			|| (reg_wr_in && reg_addr_in == vpic_pkg::REG_CTRL && reg_wdata_in[vpic_pkg::CTRL_EN_BIT]))
			next_irq_en = 1'b1;
	end

	// Reset leaves the reset vector pending so the core fetches it first
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			pend          <= NS'(1);
			en_hi         <= '0;
			en_lo         <= '0;
			edge_sel      <= 8'h00;
			irq_en        <= 1'b0;
			reg_rdata_out <= 8'h00;
		end
		else
		begin
			pend          <= next_pend;
			en_hi         <= next_en_hi;
			en_lo         <= next_en_lo;
			edge_sel      <= next_edge;
			irq_en        <= next_irq_en;
			reg_rdata_out <= next_rdata;
		end
	end

	assign master_irq_enable_out = irq_en;

	// ************************************************************
	// Arbitration: highest level, then table order
	// ************************************************************
	logic [1:0] lvl [NS];      // Effective level per position
	logic       win_vld;       // Some position may be offered
	int         win_idx;       // Winning position

	always_comb
	begin
		win_vld = 1'b0;
		win_idx = 0;
		for (int i = 0; i < NS; i++)
			lvl[i] = (i < vpic_pkg::NFIX) ? vpic_pkg::LVL_3 : {en_hi[i], en_lo[i]};
		// Peripherals need the master enable; fixed sources do not
		for (int l = vpic_pkg::LVL_3; l >= vpic_pkg::LVL_1; l--)
			for (int i = NS - 1; i >= 0; i--)
				if (!win_vld_at(l) && pend[i] && lvl[i] == 2'(l) && (irq_en || i < vpic_pkg::NFIX))
					win_idx = i;
		for (int i = 0; i < NS; i++)
			if (pend[i] && lvl[i] != vpic_pkg::LVL_OFF && (irq_en || i < vpic_pkg::NFIX))
				win_vld = 1'b1;
	end

	// True when a position above level l is eligible, so lower levels may not win
	function automatic logic win_vld_at(input int l);
		logic f;
		f = 1'b0;
		for (int i = 0; i < NS; i++)
			if (pend[i] && int'(lvl[i]) > l && (irq_en || i < vpic_pkg::NFIX))
				f = 1'b1;
		return f;
	endfunction : win_vld_at

	// ************************************************************
	// Vector fetch and offer
	// ************************************************************
	typedef enum logic [4:0]
	{
		VPC_IDLE  = 5'h01,
		VPC_RD_HI = 5'h02,
		VPC_RD_LO = 5'h04,
		VPC_CATCH = 5'h08,
		VPC_OFFER = 5'h10
	} vpc_fetch_e;

	vpc_fetch_e  state;
	vpc_fetch_e  next_state;
	logic [15:0] next_maddr;
	logic        next_mrd;
	logic [7:0]  vec_hi;       // High byte of the vector
	logic [7:0]  next_vec_hi;
	logic [15:0] vector;       // Offered vector
	logic [15:0] next_vector;
	logic        irq_req;
	logic        next_irq_req;
	int          next_cur;
	logic        cur_live;     // Offered position still eligible

	always_comb
	begin
		next_state   = state;
		next_maddr   = mem_addr_out;
		next_mrd     = 1'b0;
		next_vec_hi  = vec_hi;
		next_vector  = vector;
		next_irq_req = 1'b0;
		next_cur     = cur_idx;
		cur_live     = pend[cur_idx] && (irq_en || cur_idx < vpic_pkg::NFIX);
		ack_take     = (state == VPC_OFFER) && link.ack;
		case (state)
			VPC_IDLE:
			begin
				if (win_vld)
				begin
					next_state = VPC_RD_HI;
					next_cur   = win_idx;
					next_maddr = vpic_pkg::vec_of(win_idx);
					next_mrd   = 1'b1;
				end
			end
			VPC_RD_HI:
			begin
				// High byte at even location, low byte right after
				next_state = VPC_RD_LO;
				next_maddr = mem_addr_out | vpic_pkg::VEC_ODD;
				next_mrd   = 1'b1;
			end
			VPC_RD_LO:
			begin
				next_state  = VPC_CATCH;
				next_vec_hi = mem_data_in;
			end
			VPC_CATCH:
			begin
				next_state   = VPC_OFFER;
				next_vector  = {vec_hi, mem_data_in};
				next_irq_req = 1'b1;
			end
			VPC_OFFER:
			begin
				// Withdraw when taken or when software cancelled the request
				if (!ack_take && cur_live)
					next_irq_req = 1'b1;
				else
					next_state = VPC_IDLE;
			end
			default: next_state = VPC_IDLE;
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state        <= VPC_IDLE;
			mem_addr_out <= 16'h0000;
			mem_rd_out   <= 1'b0;
			vec_hi       <= 8'h00;
			vector       <= 16'h0000;
			irq_req      <= 1'b0;
			cur_idx      <= 0;
		end
		else
		begin
			state        <= next_state;
			mem_addr_out <= next_maddr;
			mem_rd_out   <= next_mrd;
			vec_hi       <= next_vec_hi;
			vector       <= next_vector;
			irq_req      <= next_irq_req;
			cur_idx      <= next_cur;
		end
	end

	// Offer drive straight from flip-flops
	assign link.irq_req = irq_req;
	assign link.vector  = vector;
endmodule : vpic_ctrl

// file: bench/vpic_asserts.sv
// Link checks between the interrupt controller and the core end
`timescale 1ns/100ps
module vpic_asserts
(
	input  wire logic        clock_in,
	input  wire logic        rst_b_in,
	input  wire logic        irq_req,
	input  wire logic [15:0] vector,
	input  wire logic        ack,
	input  wire logic        ei,
	input  wire logic        di,
	input  wire logic        return_from_handler_instruction,
	input  wire logic        trap_instr,
	input  wire logic        ill_trap,
	input  wire logic        master_irq_enable_out
);
	logic seen;       // An offer was seen since reset
	logic next_seen;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	// Remember the first offer, since only that one must be the reset vector
	always_comb next_seen = seen | irq_req;
	always_ff @(posedge clock_in or negedge rst_b_in)
		if (!rst_b_in)
			seen <= 1'b0;
		else
			seen <= next_seen;
	sequence s_taken;
		irq_req && ack;
	endsequence
	sequence s_gap;
		!irq_req [*3];
	endsequence
	first_vec_a: assert property (irq_req && !seen |-> vector[7:0] == 8'h02)
		else $error("first offer is not the reset vector");
	vec_even_a: assert property (irq_req |-> !vector[0])
		else $error("offered vector is odd");
	vec_table_a: assert property (irq_req |-> vector[7:0] inside {8'h02, 8'h04, 8'h06, 8'h0A, 8'h0C, 8'h16,
		8'h3A, 8'h3C, [8'h18:8'h26], [8'h30:8'h36]}) else $error("offered vector not in table");
	vec_hold_a: assert property (irq_req && !ack ##1 irq_req |-> $stable(vector))
		else $error("vector changed during offer");
	ack_offer_a: assert property (ack |-> irq_req)
		else $error("ack outside an offer");
	ack_drop_a: assert property (s_taken |=> s_gap)
		else $error("offer not withdrawn after ack");
	ack_clr_en_a: assert property (s_taken ##0 !(ei || return_from_handler_instruction) |=> !master_irq_enable_out)
		else $error("ack left master enable set");
	en_clr_a: assert property ((di || trap_instr || ill_trap) && !ei && !return_from_handler_instruction |=> !master_irq_enable_out)
		else $error("master enable not cleared");
	en_set_a: assert property (ei || return_from_handler_instruction |=> master_irq_enable_out)
		else $error("master enable not set");
endmodule : vpic_asserts

// file: bench/vectored_priority_irq_controller_tb_top.sv
// Self-checking bench for the controller and core ends
`timescale 1ns/100ps
module vectored_priority_irq_controller_tb_top;
	logic        clock_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic        accept = 1'b0;   // Core may take offers
	logic [11:0] ev = '0;         // t1 t0 adc cmp wdt posc wosc ei di return_from_handler_instruction trap ill
	logic [7:0]  pa = '0;
	logic [3:0]  pc = '0;
	logic [3:0]  addr = '0;
	logic [7:0]  wdata = '0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  mdata = '0;
	logic [7:0]  rdata;
	logic [15:0] maddr;
	logic        mrd;             // Program memory read strobe
	logic        en;
	logic [15:0] vout;
	logic        vld;
	int          failures = 0;
	int          samples_checked = 0;
	int          seed = 34512;
	int          cyc = 0;
	logic [7:0]  h0, l0, h1, l1, q0, q1;
	logic [7:0]  trap_loc [4] = '{8'h04, 8'h3A, 8'h3C, 8'h06};
	vpic_if link ();
	vpic_ctrl i_vpic_ctrl (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link), .timer1_pulse_in(ev[0]),
		.timer0_pulse_in(ev[1]), .adc_pulse_in(ev[2]), .cmp_pulse_in(ev[3]), .wdt_pulse_in(ev[4]),
		.wdt_irq_en_in(1'b1), .posc_fail_in(ev[5]), .wosc_fail_in(ev[6]), .pa_pin_in(pa), .pc_pin_in(pc),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.mem_addr_out(maddr), .mem_rd_out(mrd), .mem_data_in(mdata), .master_irq_enable_out(en));
	vpic_core_end i_vpic_core_end (.clock_in(clock_in), .rst_b_in(rst_b_in), .link(link), .accept_in(accept),
		.ei_in(ev[7]), .di_in(ev[8]), .return_from_handler_instruction_in(ev[9]), .trap_in(ev[10]), .illegal_in(ev[11]),
		.vector_out(vout), .vector_vld_out(vld));
	vpic_asserts i_vpic_asserts (.clock_in(clock_in), .rst_b_in(rst_b_in), .irq_req(link.irq_req),
		.vector(link.vector), .ack(link.ack), .ei(link.ei), .di(link.di), .return_from_handler_instruction(link.return_from_handler_instruction),
		.trap_instr(link.trap_instr), .ill_trap(link.ill_trap), .master_irq_enable_out(en));
	always #12.5 clock_in = ~clock_in;
	// Program memory: distinct high byte so a swapped fetch shows up; no strobe gives zero
	always @(posedge clock_in)
		mdata <= !mrd ? 8'h00 : maddr[0] ? maddr[7:0] - 8'h01 : 8'hA5;
	// Hang guard, far above the several hundred cycles the run needs
	always @(posedge clock_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			wrap_up();
		end
	end
	// ************************************************************
	// Bus, event and comparison tasks
	// ************************************************************
	task chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		@(negedge clock_in);
		chk({8'h00, rdata}, {8'h00, e});
	endtask : rd_reg
	task pulse(input logic [11:0] m);
		@(posedge clock_in);
		ev <= m;
		@(posedge clock_in);
		ev <= '0;
		repeat (2) @(posedge clock_in);
	endtask : pulse
	task nextv(input logic [7:0] loc);
		int n;
		n = 0;
		@(negedge clock_in);
		while (vld !== 1'b1 && n < 80)
		begin
			n++;
			@(negedge clock_in);
		end
		chk(vout, {8'hA5, loc});
	endtask : nextv
	task wrap_up();
		$display("checks=%0d mismatches=%0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// Vector location of bit b of request group g
	function automatic logic [7:0] loc_of(input int g, input int b);
		if (g == 0)
			return (b == 6) ? 8'h0A : (b == 5) ? 8'h0C : 8'h16;
		return (g == 1) ? 8'h18 + 8'(2 * (7 - b)) : 8'h30 + 8'(2 * (3 - b));
	endfunction : loc_of
	// Highest level wins, table order breaks ties
	function automatic logic [7:0] best();
		logic [1:0] lv;
		logic [1:0] bl;
		logic [7:0] r;
		bl = 2'h0;
		r = 8'h00;
		for (int g = 0; g < 2; g++)
			for (int b = 7; b >= 0; b--)
			begin
				lv = g ? {h1[b], l1[b]} : {h0[b], l0[b]};
				if ((g ? q1[b] : q0[b]) && lv > bl)
				begin
					bl = lv;
					r = loc_of(g, b);
				end
			end
		return r;
	endfunction : best
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_b_in <= 1'b1;
		accept <= 1'b1;
		nextv(8'h02);
		rd_reg(vpic_pkg::REG_CTRL, 8'h00);
		rd_reg(4'hC, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			pulse(12'h080 << i);
			rd_reg(vpic_pkg::REG_CTRL, i[0] ? 8'h00 : 8'h80);
		end
		wr_reg(vpic_pkg::REG_CTRL, 8'h80);
		rd_reg(vpic_pkg::REG_CTRL, 8'h80);
		wr_reg(vpic_pkg::REG_CTRL, 8'h00);
		rd_reg(vpic_pkg::REG_CTRL, 8'h00);
		$display("master enable test done");
		@(posedge clock_in);
		accept <= 1'b0;
		pulse(12'h870);
		accept <= 1'b1;
		for (int i = 0; i < 4; i++)
			nextv(trap_loc[i]);
		$display("trap order test done");
		wr_reg(vpic_pkg::REG_EN0H, 8'hFF);
		wr_reg(vpic_pkg::REG_EN1H, 8'hFF);
		wr_reg(vpic_pkg::REG_EN2H, 8'hFF);
		wr_reg(vpic_pkg::REG_REQ0, 8'h61);
		wr_reg(vpic_pkg::REG_REQ1, 8'hFF);
		wr_reg(vpic_pkg::REG_REQ2, 8'h0F);
		for (int i = 0; i < 15; i++)
		begin
			pulse(12'h200);
			nextv(i < 3 ? loc_of(0, i == 0 ? 6 : i == 1 ? 5 : 0) : i < 11 ? loc_of(1, 10 - i) : loc_of(2, 14 - i));
		end
		rd_reg(vpic_pkg::REG_REQ1, 8'h00);
		wr_reg(vpic_pkg::REG_EN2H, 8'h00);
		$display("table order test done");
		for (int it = 0; it < 8; it++)
		begin
			h0 = 8'($random(seed));
			l0 = 8'($random(seed));
			h1 = 8'($random(seed));
			l1 = 8'($random(seed)) | 8'h01;
			q0 = 8'($random(seed)) & 8'h61;
			q1 = 8'($random(seed)) | 8'h01;
			wr_reg(vpic_pkg::REG_EN0H, h0);
			wr_reg(vpic_pkg::REG_EN0L, l0);
			wr_reg(vpic_pkg::REG_EN1H, h1);
			wr_reg(vpic_pkg::REG_EN1L, l1);
			wr_reg(vpic_pkg::REG_REQ0, q0);
			wr_reg(vpic_pkg::REG_REQ1, q1);
			pulse(12'h080);
			nextv(best());
			wr_reg(vpic_pkg::REG_REQ0, 8'h00);
			wr_reg(vpic_pkg::REG_REQ1, 8'h00);
			rd_reg(vpic_pkg::REG_REQ1, 8'h00);
		end
		$display("random level test done");
		wr_reg(vpic_pkg::REG_EDGE, 8'h08);
		pa <= 8'h08;
		repeat (6) @(posedge clock_in);
		rd_reg(vpic_pkg::REG_REQ1, 8'h08);
		pa <= 8'h04;
		repeat (6) @(posedge clock_in);
		rd_reg(vpic_pkg::REG_REQ1, 8'h08);
		wr_reg(vpic_pkg::REG_REQ1, 8'h00);
		pulse(12'h008);
		rd_reg(vpic_pkg::REG_REQ1, 8'h40);
		pc <= 4'h2;
		repeat (6) @(posedge clock_in);
		rd_reg(vpic_pkg::REG_REQ2, 8'h02);
		wr_reg(vpic_pkg::REG_REQ2, 8'h00);
		pc <= 4'h0;
		repeat (6) @(posedge clock_in);
		rd_reg(vpic_pkg::REG_REQ2, 8'h02);
		@(posedge clock_in);
		ev <= 12'h001;
		addr <= vpic_pkg::REG_REQ0;
		wdata <= 8'h00;
		wr <= 1'b1;
		@(posedge clock_in);
		ev <= '0;
		wr <= 1'b0;
		rd_reg(vpic_pkg::REG_REQ0, 8'h40);
		$display("pin and collision test done");
		wrap_up();
	end
endmodule : vectored_priority_irq_controller_tb_top
